// ===== iob_diag_csr.sv
// I/O bridge control/status slice: parity injection, PCI resets, sense pins.
// Assumes an APB master on pclk, active-low sense pins and pulse-style bus events.
`timescale 1ns/1ps
`default_nettype none
module iob_diag_csr
  import iob_pkg::*;
#(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned CAP_W = 64
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic prdata_par,
  output logic pready,
  output logic pslverr,
  input wire logic sysbus_reset,
  input wire logic [7:0] sense_pin_n,
  input wire logic cmd_phase_done,
  output logic cmd_lw0_bad_par,
  output logic cmd_lw2_bad_par,
  output logic dma_hexword0_parity_inject,
  output logic dma_hexword1_parity_inject,
  output logic pci_bus_rst_n,
  output logic pci_if_reset,
  input wire logic [3:0] sysbus_err_evt,
  input wire logic [CAP_W-1:0] sysbus_err_cmd_addr,
  output logic hw_err_irq
);
  initial begin
    if (ADDR_W < 4 || ADDR_W > 12) begin
      $error("ADDR_W must lie in 4..12");
    end
    if (CAP_W < 33 || CAP_W > 64) begin
      $error("CAP_W must lie in 33..64");
    end
  end

  // Bus decode
  iob_apb_st_t apb_st_r;
  iob_apb_st_t apb_st_nxt;
  logic [11:0] addr12;
  logic sel_csr;
  logic sel_err;
  logic sel_cap_lo;
  logic sel_cap_hi;
  logic mapped;
  logic acc;
  logic wr_acc;
  logic rd_acc;
  logic wr_csr;
  logic wr_err;

  assign addr12 = 12'(paddr);
  assign sel_csr = (addr12 == IOB_CSR_OFF);
  assign sel_err = (addr12 == IOB_ERR_STAT_OFF);
  assign sel_cap_lo = (addr12 == IOB_CAP_LO_OFF);
  assign sel_cap_hi = (addr12 == IOB_CAP_HI_OFF);
  assign mapped = sel_csr | sel_err | sel_cap_lo | sel_cap_hi;
  // A write only lands in a true access phase, never on a stray penable
  assign acc = psel & penable & (apb_st_r == IOB_APB_SETUP);
  assign wr_acc = acc & pwrite & mapped;
  assign rd_acc = acc & ~pwrite;
  // Byte lane 1 holds bits 15:8, lanes 2 and 3 the rest of the slice
  assign wr_csr = wr_acc & sel_csr;
  assign wr_err = wr_acc & sel_err;

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;

  always_comb begin
    apb_st_nxt = IOB_APB_IDLE;
    case (apb_st_r)
      IOB_APB_IDLE: begin
        apb_st_nxt = psel ? IOB_APB_SETUP : IOB_APB_IDLE;
      end
      IOB_APB_SETUP: begin
        apb_st_nxt = IOB_APB_ACCESS;
      end
      IOB_APB_ACCESS: begin
        apb_st_nxt = (psel && !penable) ? IOB_APB_SETUP : IOB_APB_IDLE;
      end
      default: begin
        apb_st_nxt = IOB_APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_st_r <= IOB_APB_IDLE;
    end else begin
      apb_st_r <= apb_st_nxt;
    end
  end

  // Writable control bits
  logic [31:0] wdata_m;
  logic [31:0] wmask;
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic lw0_armed;
  logic lw2_armed;
  logic rd_even_armed;

  assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  assign wdata_m = pwdata & wmask;

  // Level controls: PCI resets, DMA injection and error enable
  assign ctrl_nxt = (ctrl_r & ~(IOB_CSR_WMASK & wmask)) | (wdata_m & IOB_CSR_WMASK);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= IOB_CSR_RESET;
    end else if (sysbus_reset) begin
      ctrl_r <= IOB_CSR_RESET;
    end else if (wr_csr) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // One-shot injections consumed by hardware events
  iob_oneshot u_lw0 (
    .pclk(pclk),
    .presetn(presetn),
    .clr_sync(sysbus_reset),
    .wr_en(wr_csr & pstrb[1]),
    .wr_val(pwdata[IOB_BIT_CMD_LW0]),
    .consume(cmd_phase_done),
    .armed(lw0_armed)
  );

  iob_oneshot u_lw2 (
    .pclk(pclk),
    .presetn(presetn),
    .clr_sync(sysbus_reset),
    .wr_en(wr_csr & pstrb[1]),
    .wr_val(pwdata[IOB_BIT_CMD_LW2]),
    .consume(cmd_phase_done),
    .armed(lw2_armed)
  );

  // Consumed by the next register read that completes
  iob_oneshot u_rd_even (
    .pclk(pclk),
    .presetn(presetn),
    .clr_sync(sysbus_reset),
    .wr_en(wr_csr & pstrb[1]),
    .wr_val(pwdata[IOB_BIT_RD_EVEN]),
    .consume(rd_acc & mapped),
    .armed(rd_even_armed)
  );

  // Command injections held during the command/address phase until it ends; DMA injections are levels
  assign cmd_lw0_bad_par = lw0_armed;
  assign cmd_lw2_bad_par = lw2_armed;
  assign dma_hexword1_parity_inject = ctrl_r[IOB_BIT_DMA_HW1];
  assign dma_hexword0_parity_inject = ctrl_r[IOB_BIT_DMA_HW0];
  // Bus reset depends only on its own bit, never on the interface reset
  assign pci_bus_rst_n = ~ctrl_r[IOB_BIT_PCI_BRST];
  assign pci_if_reset = ctrl_r[IOB_BIT_PCI_IRST];

  // Sense pins, sampled once; meaningless while visibility mode repurposes them
  logic [4:0] sense_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_r <= 5'h00;
    end else begin
      sense_r[0] <= ~sense_pin_n[IOB_PIN_SLOT2_B];
      sense_r[1] <= ~sense_pin_n[IOB_PIN_PSERR];
      sense_r[2] <= ~sense_pin_n[IOB_PIN_SPARE7];
      sense_r[3] <= ~sense_pin_n[IOB_PIN_SLOT1_A];
      sense_r[4] <= ~sense_pin_n[IOB_PIN_SLOT1_B];
    end
  end

  // Error flags and capture
  logic [3:0] err_stat;
  logic [3:0] err_w1c;
  logic [CAP_W-1:0] err_cap;
  logic [31:0] err_word;

  assign err_w1c = {4{wr_err}} & {pwdata[IOB_ERR_SYNC], pwdata[IOB_ERR_WDPAR],
    pwdata[IOB_ERR_NOACK], pwdata[IOB_ERR_UNCORR]};

  iob_err_capture #(
    .CAP_W(CAP_W)
  ) u_err (
    .pclk(pclk),
    .presetn(presetn),
    .clr_sync(sysbus_reset),
    .enable(ctrl_r[IOB_BIT_ERR_IEN]),
    .evt(sysbus_err_evt),
    .evt_cmd_addr(sysbus_err_cmd_addr),
    .w1c(err_w1c),
    .status(err_stat),
    .capture(err_cap)
  );

  always_comb begin
    err_word = 32'h0000_0000;
    err_word[IOB_ERR_UNCORR] = err_stat[0];
    err_word[IOB_ERR_NOACK] = err_stat[1];
    err_word[IOB_ERR_WDPAR] = err_stat[2];
    err_word[IOB_ERR_SYNC] = err_stat[3];
  end

  assign hw_err_irq = ctrl_r[IOB_BIT_ERR_IEN] & (|err_stat);

  // Read data
  logic [31:0] csr_word;
  logic [31:0] rd_mux;
  logic [31:0] prdata_r;
  logic par_flip_r;

  // Read-only bits come from the pin samples; writes never reach them
  always_comb begin
    csr_word = ctrl_r;
    csr_word[IOB_BIT_CMD_LW0] = lw0_armed;
    csr_word[IOB_BIT_CMD_LW2] = lw2_armed;
    csr_word[IOB_BIT_RD_EVEN] = rd_even_armed;
    csr_word[IOB_BIT_SLOT2_B] = sense_r[0];
    csr_word[IOB_BIT_PSERR] = sense_r[1];
    csr_word[IOB_BIT_SPARE7] = sense_r[2];
    csr_word[IOB_BIT_SLOT1_A] = sense_r[3];
    csr_word[IOB_BIT_SLOT1_B] = sense_r[4];
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_csr) begin
      rd_mux = csr_word;
    end else if (sel_err) begin
      rd_mux = err_word;
    end else if (sel_cap_lo) begin
      rd_mux = err_cap[31:0];
    end else if (sel_cap_hi) begin
      rd_mux = 32'(err_cap[CAP_W-1:32]);
    end
  end

  // Data is latched in the setup cycle so prdata comes from a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      par_flip_r <= 1'b0;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= rd_mux;
      par_flip_r <= rd_even_armed & ~addr12[IOB_ADDR_ODD_WORD];
    end
  end

  assign prdata = prdata_r;
  // Even parity over the word, inverted for injected even longwords
  assign prdata_par = (^prdata_r) ^ par_flip_r;

  // Checks
  property p_lw0_one_shot;
    @(posedge pclk) disable iff (!presetn)
    (lw0_armed && cmd_phase_done && !wr_csr && !sysbus_reset) |=> !cmd_lw0_bad_par;
  endproperty
  a_lw0_one_shot: assert property (p_lw0_one_shot) else $error("lw0 injection outlived its phase");

  property p_lw2_one_shot;
    @(posedge pclk) disable iff (!presetn)
    (lw2_armed && cmd_phase_done && !wr_csr && !sysbus_reset) |=> !cmd_lw2_bad_par;
  endproperty
  a_lw2_one_shot: assert property (p_lw2_one_shot) else $error("lw2 injection outlived its phase");

  property p_even_flip;
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && rd_even_armed && !addr12[IOB_ADDR_ODD_WORD] && !sysbus_reset)
      |=> (prdata_par != (^prdata));
  endproperty
  a_even_flip: assert property (p_even_flip) else $error("even word read parity not inverted");

  property p_slot2_pin;
    @(posedge pclk) disable iff (!presetn)
    !sense_pin_n[IOB_PIN_SLOT2_B] |=> csr_word[IOB_BIT_SLOT2_B];
  endproperty
  a_slot2_pin: assert property (p_slot2_pin) else $error("slot2 presence not following pin");

  property p_pserr_pin;
    @(posedge pclk) disable iff (!presetn)
    ##1 csr_word[IOB_BIT_PSERR] == !$past(sense_pin_n[IOB_PIN_PSERR]);
  endproperty
  a_pserr_pin: assert property (p_pserr_pin) else $error("power error bit not following pin");

  property p_spare_pin;
    @(posedge pclk) disable iff (!presetn)
    ##1 csr_word[IOB_BIT_SPARE7] == !$past(sense_pin_n[IOB_PIN_SPARE7]);
  endproperty
  a_spare_pin: assert property (p_spare_pin) else $error("spare sense bit not following pin");

  property p_slot1_pins;
    @(posedge pclk) disable iff (!presetn)
    ##1 csr_word[IOB_BIT_SLOT1_B:IOB_BIT_SLOT1_A] ==
      ~$past({sense_pin_n[IOB_PIN_SLOT1_B], sense_pin_n[IOB_PIN_SLOT1_A]});
  endproperty
  a_slot1_pins: assert property (p_slot1_pins) else $error("slot1 presence not following pins");

  property p_dma_levels;
    @(posedge pclk) disable iff (!presetn)
    (wr_csr && pstrb[2] && !sysbus_reset) |=>
      (dma_hexword1_parity_inject == $past(pwdata[IOB_BIT_DMA_HW1]) &&
       dma_hexword0_parity_inject == $past(pwdata[IOB_BIT_DMA_HW0]));
  endproperty
  a_dma_levels: assert property (p_dma_levels) else $error("dma injection did not follow write");

  property p_bus_reset;
    @(posedge pclk) disable iff (!presetn)
    (wr_csr && pstrb[2] && pwdata[IOB_BIT_PCI_BRST] && !sysbus_reset) |=> !pci_bus_rst_n;
  endproperty
  a_bus_reset: assert property (p_bus_reset) else $error("pci bus reset not asserted");

  property p_if_reset_alone;
    @(posedge pclk) disable iff (!presetn)
    (wr_csr && pstrb[2] && pwdata[IOB_BIT_PCI_IRST] && !pwdata[IOB_BIT_PCI_BRST] && !sysbus_reset)
      |=> (pci_if_reset && pci_bus_rst_n);
  endproperty
  a_if_reset_alone: assert property (p_if_reset_alone) else $error("interface reset misbehaved");

  property p_sysbus_clear;
    @(posedge pclk) disable iff (!presetn)
    sysbus_reset |=> (ctrl_r == IOB_CSR_RESET && !lw0_armed && !lw2_armed && !rd_even_armed);
  endproperty
  a_sysbus_clear: assert property (p_sysbus_clear) else $error("control bits survived bus reset");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    (ctrl_r[IOB_BIT_ERR_IEN] && |sysbus_err_evt && !sysbus_reset && !wr_csr) |=> hw_err_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("error interrupt not raised");

  property p_ro_write;
    @(posedge pclk) disable iff (!presetn)
    wr_csr |-> !pslverr ##1
      (csr_word[IOB_BIT_SLOT1_B:IOB_BIT_SLOT2_B] ==
       ~$past({sense_pin_n[IOB_PIN_SLOT1_B], sense_pin_n[IOB_PIN_SLOT1_A], sense_pin_n[IOB_PIN_SPARE7],
               sense_pin_n[IOB_PIN_PSERR], sense_pin_n[IOB_PIN_SLOT2_B]}));
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("register write flagged an error");
endmodule : iob_diag_csr
`default_nettype wire

// ===== iob_pkg.sv
// Constants for the I/O bridge diagnostic and reset control slice.
// Assumes a 32-bit APB register port and active-low sense pins.
package iob_pkg;
  // Register byte offsets
  localparam logic [11:0] IOB_CSR_OFF = 12'h000;
  localparam logic [11:0] IOB_ERR_STAT_OFF = 12'h004;
  localparam logic [11:0] IOB_CAP_LO_OFF = 12'h008;
  localparam logic [11:0] IOB_CAP_HI_OFF = 12'h00c;
  // Byte address bit that tells odd longwords from even ones
  localparam int unsigned IOB_ADDR_ODD_WORD = 2;
  // Control/status field positions
  localparam int unsigned IOB_BIT_CMD_LW0 = 12;
  localparam int unsigned IOB_BIT_CMD_LW2 = 13;
  localparam int unsigned IOB_BIT_RD_EVEN = 14;
  localparam int unsigned IOB_BIT_SLOT2_B = 15;
  localparam int unsigned IOB_BIT_PSERR = 16;
  localparam int unsigned IOB_BIT_SPARE7 = 17;
  localparam int unsigned IOB_BIT_SLOT1_A = 18;
  localparam int unsigned IOB_BIT_SLOT1_B = 19;
  localparam int unsigned IOB_BIT_DMA_HW1 = 20;
  localparam int unsigned IOB_BIT_DMA_HW0 = 21;
  localparam int unsigned IOB_BIT_PCI_BRST = 22;
  localparam int unsigned IOB_BIT_PCI_IRST = 23;
  localparam int unsigned IOB_BIT_ERR_IEN = 24;
  // Sense pin numbers
  localparam int unsigned IOB_PIN_SLOT1_A = 2;
  localparam int unsigned IOB_PIN_SLOT1_B = 3;
  localparam int unsigned IOB_PIN_SLOT2_B = 5;
  localparam int unsigned IOB_PIN_PSERR = 6;
  localparam int unsigned IOB_PIN_SPARE7 = 7;
  // Error status positions
  localparam int unsigned IOB_ERR_UNCORR = 0;
  localparam int unsigned IOB_ERR_NOACK = 1;
  localparam int unsigned IOB_ERR_WDPAR = 16;
  localparam int unsigned IOB_ERR_SYNC = 17;
  // Reset value and writable mask
  localparam logic [31:0] IOB_CSR_RESET = 32'h0000_0000;
  localparam logic [31:0] IOB_CSR_WMASK = 32'h01f0_7000;
  // APB tracker
  typedef enum logic [1:0] {
    IOB_APB_IDLE = 2'b00,
    IOB_APB_SETUP = 2'b01,
    IOB_APB_ACCESS = 2'b11
  } iob_apb_st_t;
endpackage : iob_pkg

// ===== iob_oneshot.sv
// One armed control bit with a hardware consume that clears it.
// Assumes consume is a one-cycle pulse in the pclk domain.
`timescale 1ns/1ps
`default_nettype none
module iob_oneshot
  import iob_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr_sync,
  input wire logic wr_en,
  input wire logic wr_val,
  input wire logic consume,
  output logic armed
);
  // A software write in the consume cycle wins, so a re-arm is never lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed <= 1'b0;
    end else if (clr_sync) begin
      armed <= 1'b0;
    end else if (wr_en) begin
      armed <= wr_val;
    end else if (consume) begin
      armed <= 1'b0;
    end
  end

  property p_consume_clears;
    @(posedge pclk) disable iff (!presetn)
    (consume && !wr_en) |=> !armed;
  endproperty
  a_consume_clears: assert property (p_consume_clears) else $error("armed bit survived its consume");
endmodule : iob_oneshot
`default_nettype wire

// ===== iob_err_capture.sv
// Sticky system-bus error flags with first-failure command capture.
// Assumes error events are one-cycle pulses with the command/address valid alongside.
`timescale 1ns/1ps
`default_nettype none
module iob_err_capture
  import iob_pkg::*;
#(
  parameter int unsigned CAP_W = 64
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr_sync,
  input wire logic enable,
  input wire logic [3:0] evt,
  input wire logic [CAP_W-1:0] evt_cmd_addr,
  input wire logic [3:0] w1c,
  output logic [3:0] status,
  output logic [CAP_W-1:0] capture
);
  initial begin
    if (CAP_W < 33 || CAP_W > 64) begin
      $error("CAP_W must lie in 33..64");
    end
  end

  logic [3:0] evt_en;
  assign evt_en = evt & {4{enable}};

  // Set beats a same-cycle write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= 4'h0;
    end else if (clr_sync) begin
      status <= 4'h0;
    end else begin
      status <= (status & ~w1c) | evt_en;
    end
  end

  // Only the first failure is kept until software or a system bus reset clears every flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture <= '0;
    end else if (|evt_en && status == 4'h0) begin
      capture <= evt_cmd_addr;
    end
  end

  property p_evt_sets;
    @(posedge pclk) disable iff (!presetn)
    (!clr_sync && |evt_en) |=> ((status & $past(evt_en)) == $past(evt_en));
  endproperty
  a_evt_sets: assert property (p_evt_sets) else $error("enabled error did not set its flag");
endmodule : iob_err_capture
`default_nettype wire

// ===== iob_diag_csr_bench.sv
// Self-checking bench for the I/O bridge diagnostic and reset control slice.
// Assumes the design's zero-wait APB slave and one-flop sampling of the sense pins.
`timescale 1ns/1ps
`default_nettype none
module iob_diag_csr_bench;
  import iob_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, sysbus_reset, cmd_phase_done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] pstrb, sysbus_err_evt;
  logic [7:0] sense_pin_n;
  logic [63:0] sysbus_err_cmd_addr;
  logic prdata_par, pready, pslverr, rpar, rerr;
  logic cmd_lw0_bad_par, cmd_lw2_bad_par, dma_hexword0_parity_inject, dma_hexword1_parity_inject;
  logic pci_bus_rst_n, pci_if_reset, hw_err_irq;
  logic [6:0] outs;
  int fails, compares, i;
  // Sense pin patterns beside the status bits they should raise
  logic [7:0] row_pins [8] = '{8'hff, 8'hdf, 8'hbf, 8'h7f, 8'hfb, 8'hf7, 8'h00, 8'hec};
  logic [31:0] row_exp [8] = '{32'h0, 32'h0000_8000, 32'h0001_0000, 32'h0002_0000,
                               32'h0004_0000, 32'h0008_0000, 32'h000f_8000, 32'h0};
  assign outs = {cmd_lw0_bad_par, cmd_lw2_bad_par, dma_hexword0_parity_inject,
                 dma_hexword1_parity_inject, pci_bus_rst_n, pci_if_reset, hw_err_irq};

  iob_diag_csr #(.ADDR_W(12), .CAP_W(64)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .prdata_par(prdata_par),
    .pready(pready), .pslverr(pslverr), .sysbus_reset(sysbus_reset), .sense_pin_n(sense_pin_n),
    .cmd_phase_done(cmd_phase_done), .cmd_lw0_bad_par(cmd_lw0_bad_par),
    .cmd_lw2_bad_par(cmd_lw2_bad_par), .dma_hexword0_parity_inject(dma_hexword0_parity_inject),
    .dma_hexword1_parity_inject(dma_hexword1_parity_inject), .pci_bus_rst_n(pci_bus_rst_n),
    .pci_if_reset(pci_if_reset), .sysbus_err_evt(sysbus_err_evt),
    .sysbus_err_cmd_addr(sysbus_err_cmd_addr), .hw_err_irq(hw_err_irq)
  );

  always #4 pclk = ~pclk;

  task results;
    if (fails == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the answer is taken at the rising edge where pready is seen high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      fails++;
      results();
    end
    rdat = prdata;
    rpar = prdata_par;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Read and compare data, plain parity and no error
  task rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'hf);
    chk(rdat, exp);
    chk({31'h0, rpar}, {31'h0, ^exp});
    chk({31'h0, rerr}, 32'h0);
  endtask : rchk

  task outchk(input logic [6:0] exp);
    @(negedge pclk);
    chk({25'h0, outs}, {25'h0, exp});
  endtask : outchk

  task evt(input logic [3:0] e, input logic [63:0] ca);
    @(posedge pclk);
    sysbus_err_evt <= e;
    sysbus_err_cmd_addr <= ca;
    @(posedge pclk);
    sysbus_err_evt <= 4'h0;
  endtask : evt

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    sysbus_reset = 1'b0;
    sense_pin_n = 8'hff;
    cmd_phase_done = 1'b0;
    sysbus_err_evt = 4'h0;
    sysbus_err_cmd_addr = 64'h0;
    fails = 0;
    compares = 0;
    repeat (2) @(posedge pclk);
    outchk(7'b0000100);
    @(posedge pclk);
    presetn <= 1'b1;
    rchk(IOB_CSR_OFF, 32'h0);
    // Sense pin table; visibility mode is never on, so the status bits stay meaningful
    for (i = 0; i < 8; i++) begin
      @(posedge pclk);
      sense_pin_n <= row_pins[i];
      repeat (2) @(posedge pclk);
      rchk(IOB_CSR_OFF, row_exp[i]);
      chk({31'h0, |rdat[IOB_BIT_SLOT1_B:IOB_BIT_SLOT1_A]}, {31'h0, |row_exp[i][19:18]});
      chk({31'h0, rdat[IOB_BIT_SLOT2_B]}, {31'h0, row_exp[i][15]});
    end
    // Read-only bits ignore writes and keep following the pins
    apb(1'b1, IOB_CSR_OFF, 32'h000f_8000, 4'h6);
    chk({31'h0, rerr}, 32'h0);
    rchk(IOB_CSR_OFF, 32'h0);
    @(posedge pclk);
    sense_pin_n <= 8'hff;
    // Interface reset alone leaves the bus reset off
    apb(1'b1, IOB_CSR_OFF, 32'h0080_0000, 4'h4);
    outchk(7'b0000110);
    apb(1'b1, IOB_CSR_OFF, 32'h0040_0000, 4'h4);
    outchk(7'b0000000);
    apb(1'b1, IOB_CSR_OFF, 32'h0, 4'hf);
    outchk(7'b0000100);
    // Byte enables gate the control bits
    apb(1'b1, IOB_CSR_OFF, 32'hffff_ffff, 4'h0);
    rchk(IOB_CSR_OFF, 32'h0);
    apb(1'b1, IOB_CSR_OFF, 32'hffff_ffff, 4'h8);
    rchk(IOB_CSR_OFF, 32'h0100_0000);
    // All controls on; even-word read parity flips once
    apb(1'b1, IOB_CSR_OFF, 32'hffff_ffff, 4'hf);
    outchk(7'b1111010);
    apb(1'b0, IOB_CSR_OFF, 32'h0, 4'hf);
    chk(rdat, 32'h01f0_7000);
    chk({31'h0, rpar}, {31'h0, ~^32'h01f0_7000});
    rchk(IOB_CSR_OFF, 32'h01f0_3000);
    // Odd word read consumes the injection without flipping
    apb(1'b1, IOB_CSR_OFF, 32'h01f0_7000, 4'hf);
    rchk(IOB_ERR_STAT_OFF, 32'h0);
    rchk(IOB_CSR_OFF, 32'h01f0_3000);
    // One commander phase consumes both command injections
    @(posedge pclk);
    cmd_phase_done <= 1'b1;
    @(posedge pclk);
    cmd_phase_done <= 1'b0;
    outchk(7'b0011010);
    @(posedge pclk);
    cmd_phase_done <= 1'b1;
    @(posedge pclk);
    cmd_phase_done <= 1'b0;
    outchk(7'b0011010);
    // System bus reset clears every control bit
    @(posedge pclk);
    sysbus_reset <= 1'b1;
    @(posedge pclk);
    sysbus_reset <= 1'b0;
    outchk(7'b0000100);
    rchk(IOB_CSR_OFF, 32'h0);
    // Errors ignored while the enable is off
    evt(4'h1, 64'h1111_2222_3333_4444);
    rchk(IOB_ERR_STAT_OFF, 32'h0);
    outchk(7'b0000100);
    apb(1'b1, IOB_CSR_OFF, 32'h0100_0000, 4'h8);
    evt(4'h2, 64'h0123_4567_89ab_cdef);
    rchk(IOB_ERR_STAT_OFF, 32'h0000_0002);
    outchk(7'b0000101);
    evt(4'hd, 64'hffff_eeee_dddd_cccc);
    rchk(IOB_ERR_STAT_OFF, 32'h0003_0003);
    rchk(IOB_CAP_LO_OFF, 32'h89ab_cdef);
    rchk(IOB_CAP_HI_OFF, 32'h0123_4567);
    apb(1'b1, IOB_ERR_STAT_OFF, 32'h0003_0003, 4'hf);
    rchk(IOB_ERR_STAT_OFF, 32'h0);
    outchk(7'b0000100);
    // Unmapped place answers with an error and reads zero
    apb(1'b0, 12'h010, 32'h0, 4'hf);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0);
    apb(1'b1, 12'h010, 32'hffff_ffff, 4'hf);
    chk({31'h0, rerr}, 32'h1);
    // Power-up reset in mid-run
    apb(1'b1, IOB_CSR_OFF, 32'hffff_ffff, 4'hf);
    @(posedge pclk);
    presetn <= 1'b0;
    outchk(7'b0000100);
    @(posedge pclk);
    presetn <= 1'b1;
    rchk(IOB_CSR_OFF, 32'h0);
    results();
  end

  // Guard against a hung run
  initial begin
    #400000;
    fails++;
    results();
  end
endmodule : iob_diag_csr_bench
`default_nettype wire
